// ==== rtl/vad_pkg.sv ====
// types, constants and register map of the voice activity detector
// assumes one clock domain and an apb master on the same clock
package vad_pkg;

  // ==========================================================
  // data types
  typedef logic signed [79:0] vad_wide_t;
  typedef logic signed [35:0] vad_av_t;
  typedef logic signed [31:0] vad_acf_t;
  typedef logic signed [23:0] vad_coef_t;
  typedef logic signed [15:0] vad_rc_t;
  typedef logic [7:0] vad_lag_t;

  typedef enum logic [3:0] {
    S_IDLE, S_AVG, S_LACC, S_LUPD, S_RAV, S_DM,
    S_DMEND, S_DEC, S_PER, S_DONE, S_DIV
  } vad_st_t;

  // ==========================================================
  // fixed point and algorithm constants
  localparam int Q = 14;
  localparam vad_wide_t ONE = 80'sd16384;
  localparam vad_wide_t THRESH_Q = 80'sd1114;
  localparam vad_wide_t PTH = 80'sd210000;
  localparam vad_wide_t PLEV = 80'sd560000;
  localparam vad_wide_t MARGIN = 80'sd112000000;
  localparam vad_wide_t THVAD_INIT = 80'sd1400000;
  localparam vad_wide_t RVAD0_INIT = 80'sd6;
  localparam vad_wide_t FAC_Q8 = 80'sd653;
  localparam int DEC_SH = 5;
  localparam int INC_SH = 4;
  localparam logic [3:0] ADP = 4'h8;
  localparam logic [1:0] BURST_CONST = 2'h3;
  localparam logic signed [3:0] HANG_CONST = 4'sh5;
  localparam logic signed [3:0] HANG_INIT = -4'sh1;
  localparam logic signed [8:0] LTHRESH = 9'sh002;
  localparam logic [3:0] NTHRESH = 4'h7;
  localparam vad_lag_t LAG0_INIT = 8'h15;
  localparam logic PTCH_INIT = 1'b1;
  localparam vad_wide_t PREDTH_Q15 = 80'sd1464;
  localparam vad_wide_t FREQTH_Q15 = 80'sd3188;
  localparam vad_wide_t RC_ONE = 80'sd32768;
  localparam logic [6:0] DIV_STEPS = 7'h50;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_THV = 8'h08;
  localparam logic [7:0] A_PVAD = 8'h0C;
  localparam logic [7:0] A_CNT = 8'h10;
  localparam logic [7:0] A_DM = 8'h14;
  localparam logic [7:0] A_ACF = 8'h40;
  localparam logic [7:0] A_RC = 8'h80;
  localparam logic [7:0] A_LAG = 8'h90;

  typedef struct packed {
    vad_st_t st;
    vad_st_t ret;
    logic [3:0] m;
    logic [6:0] cnt;
    vad_acf_t [8:0] acf_in;
    vad_rc_t [3:0] rc_in;
    vad_lag_t [3:0] lag_in;
    vad_acf_t [2:0][8:0] acfh;
    vad_av_t [3:0][8:0] avh;
    vad_av_t [8:0] av0;
    vad_av_t [8:0] av1;
    vad_coef_t [8:0] a;
    vad_wide_t [8:0] rav;
    vad_wide_t [8:0] rvad;
    vad_wide_t err, num, rem, den, dm, lastdm, pvad, thvad;
    logic neg, stat, tone, ptch, vvad, vad, done;
    logic [1:0] burst;
    logic signed [3:0] hang;
    logic [3:0] adaptcnt;
    logic [2:0] oldlc, voldlc;
    vad_lag_t lagp;
    logic pready, pslverr;
    logic [31:0] prdata;
  } vad_state_t;

endpackage : vad_pkg

// ==== rtl/vad_top.sv ====
// voice activity detector with apb register access
// assumes the apb master runs on pclk and software loads
// autocorrelation, reflection and lag registers before start
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module vad_top
  import vad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic vad_flag,
  output logic frame_done
);

  // ==========================================================
  // helpers
  function automatic vad_wide_t mul(vad_wide_t x, vad_wide_t y);
    return x * y;
  endfunction : mul

  function automatic vad_wide_t absw(vad_wide_t x);
    return (x < 0) ? -x : x;
  endfunction : absw

  vad_state_t q;
  vad_state_t n;

  assign pready = q.pready;
  assign prdata = q.prdata;
  assign pslverr = q.pslverr;
  assign vad_flag = q.vad;
  assign frame_done = q.done;

  // ==========================================================
  // next state
  always_comb begin
    vad_wide_t s;
    vad_wide_t t;
    vad_wide_t f;
    vad_wide_t k;
    vad_wide_t a1;
    vad_wide_t sq;
    vad_wide_t im;
    vad_wide_t thr;
    logic [31:0] rd;
    logic bad;
    logic pred_low;
    logic [2:0] lc;
    logic [7:0] big;
    logic [7:0] mn;
    logic [7:0] lo;
    logic signed [8:0] sm;
    vad_lag_t [4:0] lg;
    s = '0;
    t = '0;
    f = '0;
    k = '0;
    a1 = '0;
    sq = '0;
    im = '0;
    thr = '0;
    rd = '0;
    bad = 1'b0;
    pred_low = 1'b0;
    lc = '0;
    big = '0;
    mn = '0;
    lo = '0;
    sm = '0;
    lg = '0;
    n = q;
    n.done = 1'b0;
    n.pready = 1'b0;

    // apb read mux, word per register, low bits only
    if (paddr >= A_ACF && paddr < A_ACF + 8'h24) begin
      rd = q.acf_in[paddr[5:2] - A_ACF[5:2]];
    end else if (paddr >= A_RC && paddr < A_RC + 8'h10) begin
      rd = {{16{q.rc_in[paddr[3:2]][15]}}, q.rc_in[paddr[3:2]]};
    end else if (paddr >= A_LAG && paddr < A_LAG + 8'h10) begin
      rd = {24'h000000, q.lag_in[paddr[3:2]]};
    end else begin
      unique case (paddr)
        A_CTRL: rd = 32'h00000000;
        A_STAT: rd = {26'h0000000, q.st != S_IDLE, q.ptch, q.tone,
                      q.stat, q.vvad, q.vad};
        A_THV: rd = q.thvad[31:0];
        A_PVAD: rd = q.pvad[31:0];
        A_CNT: rd = {20'h00000, q.adaptcnt, q.hang, 2'h0, q.burst};
        A_DM: rd = q.dm[31:0];
        default: bad = 1'b1;
      endcase
    end
    if (paddr[1:0] != 2'h0) begin
      bad = 1'b1;
    end

    // answer one cycle into the access phase
    if (psel && penable && !q.pready) begin
      n.pready = 1'b1;
      n.prdata = bad ? 32'h00000000 : rd;
      n.pslverr = bad;
    end

    // writes land at the completing edge; inputs frozen while busy
    if (psel && penable && q.pready && pwrite && !q.pslverr) begin
      if (q.st == S_IDLE) begin
        if (paddr >= A_ACF && paddr < A_ACF + 8'h24) begin
          n.acf_in[paddr[5:2] - A_ACF[5:2]] = pwdata;
        end else if (paddr >= A_RC && paddr < A_RC + 8'h10) begin
          n.rc_in[paddr[3:2]] = pwdata[15:0];
        end else if (paddr >= A_LAG && paddr < A_LAG + 8'h10) begin
          n.lag_in[paddr[3:2]] = pwdata[7:0];
        end else if (paddr == A_CTRL && pwdata[0]) begin
          n.st = S_AVG;
        end
      end
    end

    unique case (q.st)
      S_IDLE: begin
      end
      // averaging window and four frame delay line
      S_AVG: begin
        for (int i = 0; i < 9; i++) begin
          n.av0[i] = vad_av_t'(q.acf_in[i]) + q.acfh[0][i]
                     + q.acfh[1][i] + q.acfh[2][i];
          n.av1[i] = q.avh[3][i];
          n.a[i] = '0;
        end
        n.acfh = {q.acfh[1:0], q.acf_in};
        n.avh = {q.avh[2:0], n.av0};
        n.a[0] = vad_coef_t'(ONE);
        n.err = vad_wide_t'(n.av1[0]);
        n.m = 4'h1;
        n.st = S_LACC;
      end
      // levinson recursion, first coefficient held at unity
      S_LACC: begin
        for (int j = 0; j < 8; j++) begin
          if (j < q.m) begin
            s = s + mul(q.a[j], q.av1[q.m - j]);
          end
        end
        n.num = absw(s);
        n.den = q.err;
        n.rem = '0;
        n.cnt = '0;
        n.neg = (s >= 0);
        n.ret = S_LUPD;
        if (q.err <= 0) begin
          n.num = '0; // singular: treat as zero reflection
          n.st = S_LUPD;
        end else begin
          n.st = S_DIV;
        end
      end
      S_LUPD: begin
        k = q.neg ? -q.num : q.num;
        if (k > ONE - 1) begin
          k = ONE - 1;
        end
        if (k < 1 - ONE) begin
          k = 1 - ONE;
        end
        for (int j = 1; j < 8; j++) begin
          if (j < q.m) begin
            n.a[j] = vad_coef_t'(q.a[j]
                     + (mul(k, q.a[q.m - j]) >>> Q));
          end
        end
        n.a[q.m] = vad_coef_t'(k);
        n.err = q.err - (mul(mul(k, k) >>> Q, q.err) >>> Q);
        n.m = q.m + 4'h1;
        n.st = (q.m == 4'h8) ? S_RAV : S_LACC;
      end
      // signs cancel in the products, so the unity convention is kept
      S_RAV: begin
        for (int i = 0; i < 9; i++) begin
          s = '0;
          for (int j = 0; j < 9; j++) begin
            if (i + j < 9) begin
              s = s + mul(q.a[j], q.a[i + j]);
            end
          end
          n.rav[i] = s >>> Q;
        end
        n.st = S_DM;
      end
      S_DM: begin
        s = mul(q.rav[0], q.av0[0]);
        for (int i = 1; i < 9; i++) begin
          s = s + 2 * mul(q.rav[i], q.av0[i]);
        end
        n.num = absw(s);
        n.den = vad_wide_t'(q.av0[0]);
        n.rem = '0;
        n.cnt = '0;
        n.neg = (s < 0);
        n.ret = S_DMEND;
        if (q.av0[0] <= 0) begin
          n.num = '0;
          n.st = S_DMEND;
        end else begin
          n.st = S_DIV;
        end
      end
      S_DMEND: begin
        t = q.neg ? -q.num : q.num;
        n.dm = t;
        n.stat = absw(t - q.lastdm) < THRESH_Q;
        n.lastdm = t;
        // energy through the adaptive filter
        s = mul(q.rvad[0], q.acf_in[0]);
        for (int i = 1; i < 9; i++) begin
          s = s + 2 * mul(q.rvad[i], q.acf_in[i]);
        end
        n.pvad = s >>> Q;
        // normalised fourth order prediction error
        f = RC_ONE;
        for (int i = 0; i < 4; i++) begin
          f = mul(f, RC_ONE - (mul(q.rc_in[i], q.rc_in[i]) >>> 15)) >>> 15;
        end
        pred_low = f < PREDTH_Q15;
        // second order pole check from first two coefficients
        a1 = q.rc_in[0] + (mul(q.rc_in[0], q.rc_in[1]) >>> 15);
        sq = mul(a1, a1);
        im = (vad_wide_t'(q.rc_in[1]) <<< 17) - sq;
        if (im < 0) begin
          n.tone = 1'b0;
        end else if (a1 > 0) begin
          n.tone = pred_low;
        end else if ((im <<< 15) < mul(FREQTH_Q15, sq)) begin
          n.tone = 1'b0;
        end else begin
          n.tone = pred_low;
        end
        n.st = S_DEC;
      end
      // threshold adaptation, decision and hangover
      S_DEC: begin
        thr = q.thvad;
        f = mul(q.pvad, FAC_Q8) >>> 8;
        if (vad_wide_t'(q.acf_in[0]) < PTH) begin
          thr = PLEV;
        end else if (q.stat && !q.ptch && !q.tone) begin
          n.rvad = q.rav;
          if (q.adaptcnt != ADP) begin
            n.adaptcnt = q.adaptcnt + 4'h1;
          end
          t = thr - (thr >>> DEC_SH);
          if (t >= f) begin
            thr = t;
          end else begin
            t = thr + (thr >>> INC_SH);
            thr = (t < f) ? t : f;
          end
        end
        if (thr > q.pvad + MARGIN) begin
          thr = q.pvad + MARGIN;
        end
        n.thvad = thr;
        n.vvad = q.pvad > thr;
        // compare before incrementing so a saturated count cannot wrap
        n.burst = 2'h0;
        n.hang = q.hang;
        if (n.vvad) begin
          if (q.burst >= BURST_CONST - 2'h1) begin
            n.hang = HANG_CONST;
            n.burst = BURST_CONST;
          end else begin
            n.burst = q.burst + 2'h1;
          end
        end
        n.vad = n.vvad || (n.hang >= 0);
        if (n.hang >= 0) begin
          n.hang = n.hang - 4'sh1;
        end
        n.st = S_PER;
      end
      // periodicity for the next frame's adaptation gate
      S_PER: begin
        lg = {q.lag_in, q.lagp};
        for (int j = 1; j < 5; j++) begin
          big = (lg[j] > lg[j - 1]) ? lg[j] : lg[j - 1];
          lo = (lg[j] < lg[j - 1]) ? lg[j] : lg[j - 1];
          for (int i = 1; i < 4; i++) begin
            mn = (lg[i] < lg[i - 1]) ? lg[i] : lg[i - 1];
            if (big >= mn) begin
              big = big - mn;
            end
          end
          sm = $signed({1'b0, lo}) - $signed({1'b0, big});
          // residual left over after three steps rejects ratio
          if ($signed({1'b0, big}) < LTHRESH || sm < LTHRESH) begin
            lc = lc + 3'h1;
          end
        end
        n.voldlc = q.oldlc;
        n.oldlc = lc;
        n.ptch = ({1'b0, lc} + {1'b0, q.oldlc}) >= NTHRESH;
        n.lagp = q.lag_in[3];
        n.st = S_DONE;
      end
      S_DONE: begin
        n.done = 1'b1;
        n.st = S_IDLE;
      end
      // shared restoring divider, one quotient bit per cycle
      S_DIV: begin
        t = {q.rem[78:0], q.num[79]};
        s = {q.num[78:0], 1'b0};
        if ($unsigned(t) >= $unsigned(q.den)) begin
          t = t - q.den;
          s[0] = 1'b1;
        end
        n.rem = t;
        n.num = s;
        n.cnt = q.cnt + 7'h01;
        if (q.cnt == DIV_STEPS - 7'h01) begin
          n.st = q.ret;
        end
      end
      default: n.st = S_IDLE;
    endcase
  end

  // ==========================================================
  // state register; reset loads the documented start values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st <= S_IDLE;
      q.ret <= S_IDLE;
      q.thvad <= THVAD_INIT;
      q.rvad[0] <= RVAD0_INIT <<< Q;
      q.hang <= HANG_INIT;
      q.lagp <= LAG0_INIT;
      q.ptch <= PTCH_INIT;
    end else begin
      q <= n;
    end
  end

endmodule : vad_top

// ==== testbench/vad_top_asserts.sv ====
// port checker for the detector: apb timing and frame handshake
// assumes binding into vad_top, single clock pclk, async reset
`timescale 1ns/10ps
module vad_top_asserts
  import vad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic vad_flag,
  input wire logic frame_done
);
  logic busy;
  logic start;
  logic bad_addr;
  // ==========
  // evaluation tracking; a start while busy is dropped
  assign start = psel && penable && pready && pwrite && paddr == A_CTRL && pwdata[0] && !busy;
  assign bad_addr = paddr[1:0] != 2'h0 || (paddr > A_DM && paddr < A_ACF)
                    || (paddr > 8'h60 && paddr < A_RC) || paddr > 8'h9C;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else begin
      busy <= start || (busy && !frame_done);
    end
  end
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // properties
  chk_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("done longer than one cycle");
  chk_done_owner: assert property (frame_done |-> busy)
    else $error("done without a start");
  chk_done_bound: assert property (start |-> ##[8:1000] frame_done)
    else $error("evaluation never finished");
  chk_flag_hold: assert property (!busy && !start |=> $stable(vad_flag))
    else $error("flag moved between frames");
  chk_ready_time: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered in two cycles");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_ready_idle: assert property (!(psel && penable) |-> !pready)
    else $error("ready outside access");
  chk_bad_addr: assert property (pready && bad_addr |-> pslverr && prdata == 32'h0)
    else $error("bad address not refused");
  chk_ctrl_read: assert property (pready && !pwrite && paddr == A_CTRL |-> prdata == 32'h0)
    else $error("control read not zero");
  cover property (start);
  cover property (frame_done && vad_flag);
  cover property (pready && pslverr);
endmodule : vad_top_asserts

bind vad_top vad_top_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .vad_flag(vad_flag), .frame_done(frame_done));

// ==== testbench/vad_enc_model.sv ====
// encoder stand-in: one frame of analysis values per gen pulse
// assumes the bench loads them over apb before each start
`timescale 1ns/10ps
module vad_enc_model (
  input wire logic pclk,
  input wire logic gen,
  input wire logic [31:0] rnd,
  output logic [8:0][31:0] acf,
  output logic [3:0][15:0] rc,
  output logic [3:0][7:0] lags
);
  // ==========
  // new frame; energy kept low so the threshold path stays known
  always_ff @(posedge pclk) begin
    if (gen) begin
      acf[0] <= 32'h13880 + (rnd % 32'h9C40);
      for (int i = 1; i < 9; i++) acf[i] <= {{22{rnd[i]}}, rnd[i +: 10]};
      // equal lags give periodic frames, else random spread
      for (int k = 0; k < 4; k++) lags[k] <= rnd[31] ? 8'h28 : 8'h14 + {1'b0, rnd[8*k +: 7]};
      case (rnd[21:20])
        2'h1: rc <= {16'h7333, 16'h7333, 16'h7EB8, 16'h7EB8}; // sharp tone
        2'h2: rc <= {16'h7333, 16'h7333, 16'h7EB8, 16'h8148}; // low pole noise
        default: rc <= '0;
      endcase
    end
  end
endmodule : vad_enc_model

// ==== testbench/tb_vad_top.sv ====
// self-checking bench: frames loaded over apb, model compares
// assumes vad_top, vad_pkg and the stand-in vad_enc_model
`timescale 1ns/10ps
module tb_vad_top;
  import vad_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, gen = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rnd = 32'h0, rd, prdata, ex;
  logic er, pready, pslverr, vad_flag, frame_done, raw, flg, ptch;
  logic [8:0][31:0] acf;
  logic [3:0][15:0] rc;
  logic [3:0][7:0] lags;
  int fails = 0, tests_run = 0, burst = 0, hang = -1, oldc = 0, vold = 0;
  int lg [5] = '{21, 0, 0, 0, 0};
  // ==========
  // clock and units
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  vad_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .vad_flag(vad_flag), .frame_done(frame_done));
  vad_enc_model u_enc (.pclk(pclk), .gen(gen), .rnd(rnd), .acf(acf), .rc(rc), .lags(lags));
  // ==========
  // helpers
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  // one apb transfer; the request stands until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      fails++;
      wrap_up();
    end
    @(posedge pclk);
  endtask : apb
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (frame_done !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fails++;
      wrap_up();
    end
  endtask : wait_done
  // periodic pair count of one frame, lag 0 from the last frame
  function automatic int lagcnt(input int l [5]);
    int c, s, m;
    c = 0;
    for (int j = 1; j <= 4; j++) begin
      s = l[j] > l[j-1] ? l[j] : l[j-1];
      for (int i = 1; i <= 3; i++) begin
        m = l[i] < l[i-1] ? l[i] : l[i-1];
        if (s >= m) s -= m;
      end
      m = l[j] < l[j-1] ? l[j] : l[j-1];
      if (s < 2 || m - s < 2) c++;
    end
    return c;
  endfunction : lagcnt
  // ==========
  // main sequence
  initial begin
    void'($urandom(96934));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, A_THV, 32'h0);
    check("thv", rd, 32'h155CC0);
    apb(1'b0, A_CNT, 32'h0);
    check("cnt", rd, 32'hF0);
    apb(1'b0, A_STAT, 32'h0);
    check("stat", rd, 32'h10);
    apb(1'b0, A_CTRL, 32'h0);
    check("ctrl", {er, rd[30:0]}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 8'h41, 32'h0);
    check("unaligned", {31'h0, er}, 32'h1);
    for (int f = 1; f <= 10; f++) begin
      rnd <= $urandom;
      gen <= 1'b1;
      @(posedge pclk);
      gen <= 1'b0;
      @(posedge pclk);
      for (int i = 0; i < 9; i++) apb(1'b1, A_ACF + 8'(4 * i), acf[i]);
      for (int i = 0; i < 4; i++) apb(1'b1, A_RC + 8'(4 * i), {16'h0, rc[i]});
      for (int i = 0; i < 4; i++) apb(1'b1, A_LAG + 8'(4 * i), {24'h0, lags[i]});
      apb(1'b1, A_CTRL, 32'h1);
      apb(1'b1, A_CTRL, 32'h1); // lands while busy, must be dropped
      wait_done();
      // reference: low energy pins threshold, filter stays at reset
      raw = 6 * int'(acf[0]) > 560000;
      burst = raw ? burst + 1 : 0;
      if (burst >= 3) begin
        hang = 5;
        burst = 3;
      end
      flg = raw || hang >= 0;
      if (hang >= 0) hang--;
      for (int i = 1; i < 5; i++) lg[i] = lags[i - 1];
      vold = oldc;
      oldc = lagcnt(lg);
      ptch = oldc + vold >= 7;
      lg[0] = lg[4];
      check("flag", {31'h0, vad_flag}, {31'h0, flg});
      ex = {27'h0, ptch, rnd[21:20] == 2'h1, f > 1 && f < 5, raw, flg};
      apb(1'b0, A_STAT, 32'h0);
      check("status", rd & (f > 4 ? 32'h3B : 32'h3F), ex);
      apb(1'b0, A_THV, 32'h0);
      check("thv", rd, 32'h88B80);
      apb(1'b0, A_PVAD, 32'h0);
      check("pvad", rd, 32'(6 * int'(acf[0])));
      apb(1'b0, A_CNT, 32'h0);
      check("cnt", rd, {24'h0, 4'(hang), 2'h0, 2'(burst)});
      if (f < 5) begin
        apb(1'b0, A_DM, 32'h0);
        check("dm", rd, 32'h4000);
      end
    end
    wrap_up();
  end
endmodule : tb_vad_top
